// [hdl/monitor_interrupt_status_mask.v]
// holds the interrupt status, mask and alert logic of the monitor
// assumes a serial bus front end giving one-cycle read and write strobes,
// never both in the same cycle
// and measurement logic supplying readings, limits and fault levels
`timescale 1ns/1ps
`include "monitor_irq_regs.vh"

// Functional notes
// - status one bit 0 flags second fan slow, bit 1 first fan slow
// - a fan flag never sets while that fan's drive output is off
// - status one bit 2 flags on-chip temperature out of limits
// - status one bit 3 flags first remote diode out of limits
// - bits 4,5,6 flag supply, analog two, analog one out of limits
// - read clears an out-of-limit flag only when its fault has gone
// - status one bit 7 is the OR of all status two bits
// - status two bit 0 sets when any temperature exceeds its critical limit, if that limit is nonzero
// - overtemp flag clears itself below critical limit minus hysteresis
// - status two bit 1 sets when hot assertion time exceeds limit 0x1E
// - status two bits 2,3 flag faults on diode one and two inputs
// - status two bits 4,5 flag faults on thermistor one and two
// - status two bits 6 and 7 read as zero
// - set mask bits 0 to 6 keep matching status one events off alert
// - mask bit 7 keeps the summary event off alert
// - both status registers and mask one reset to zero
// - out of limit means above high limit or at or below low limit
// - hot flag sets at once on assertion when limit is zero
module monitor_interrupt_status_mask #(
    parameter HOT_TICK = `HOT_TICK_CYCLES
) (
    input wire mclk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [1:0] fan_slow,
    input wire [7:0] first_fan_drive_output,
    input wire [7:0] second_fan_drive_output,
    input wire [39:0] limit_reading,
    input wire [39:0] limit_low,
    input wire [39:0] limit_high,
    input wire [31:0] crit_reading,
    input wire [31:0] crit_limit,
    input wire [7:0] overtemp_hysteresis,
    input wire hot_monitor_enable,
    input wire processor_hot_input,
    input wire [3:0] sensor_fault,
    output reg alert_n
);

    // ************************************************
    // status and mask storage
    // ************************************************
    reg [6:2] status_one_low;
    reg second_fan_stall_flag;
    reg first_fan_stall_flag;
    reg critical_overtemp_flag;
    reg processor_hot_flag;
    reg [3:0] fault_flags;
    reg [7:0] event_mask_one;
    reg [7:0] hot_limit;
    reg [21:0] tick_count;
    reg [7:0] hot_time;
    reg hot_prev;

    wire [4:0] limit_hit;
    wire [3:0] crit_over;
    wire [3:0] crit_below;
    wire [7:0] event_status_one;
    wire [7:0] event_status_two;
    wire rd_one;
    wire rd_two;
    wire second_fan_stall_flag_event;
    wire first_fan_stall_flag_event;
    wire hot_event;
    wire tick_done;
    wire summary_limit_flag;
    wire onchip_temp_limit_flag;
    wire remote_diode_one_limit_flag;
    wire diode_one_fault_flag;
    wire diode_two_fault_flag;
    wire thermistor_one_fault_flag;
    wire thermistor_two_fault_flag;
    wire [7:0] alert_terms;
    wire [6:2] next_limit_flags;
    wire next_second_fan_flag;
    wire next_first_fan_flag;
    wire next_hot_flag;
    wire [3:0] next_fault_flags;

    // ************************************************
    // limit comparators
    // ************************************************
    // one comparator per monitored channel
    genvar gi;
    generate
        for (gi = 0; gi < `LIMIT_CHANNELS; gi = gi + 1) begin : g_limit
            assign limit_hit[gi] = (limit_reading[gi*8 +: 8] > limit_high[gi*8 +: 8]) ||
                                   (limit_reading[gi*8 +: 8] <= limit_low[gi*8 +: 8]);
        end
    endgenerate

    // critical compare with hysteresis, zero limit disables channel
    generate
        for (gi = 0; gi < `CRIT_CHANNELS; gi = gi + 1) begin : g_crit
            wire [7:0] lim;
            wire [8:0] low_edge;
            assign lim = crit_limit[gi*8 +: 8];
            assign low_edge = {1'b0, lim} - {1'b0, overtemp_hysteresis};
            assign crit_over[gi] = (lim != `RST_BYTE) && (crit_reading[gi*8 +: 8] > lim);
            assign crit_below[gi] = (lim == `RST_BYTE) || low_edge[8] ||
                                    ({1'b0, crit_reading[gi*8 +: 8]} < low_edge);
        end
    endgenerate

    // ************************************************
    // event conditions
    // ************************************************
    // fan events suppressed while the drive is off
    assign second_fan_stall_flag_event = fan_slow[1] && (second_fan_drive_output != `RST_BYTE);
    assign first_fan_stall_flag_event = fan_slow[0] && (first_fan_drive_output != `RST_BYTE);

    // read strobes decoded per status register
    assign rd_one = reg_rd && (reg_addr == `ADDR_STATUS_ONE);
    assign rd_two = reg_rd && (reg_addr == `ADDR_STATUS_TWO);

    // ************************************************
    // processor-hot event
    // ************************************************
    // timer tick wraps after HOT_TICK cycles
    assign tick_done = (tick_count == HOT_TICK - 1);

    // hot event: immediate on assertion with zero limit, else on overrun
    assign hot_event = hot_monitor_enable && processor_hot_input &&
                       (((hot_limit == `RST_BYTE) && !hot_prev) ||
                        (hot_time > hot_limit));

    // ************************************************
    // named flag views
    // ************************************************
    // named views of the flag bits
    assign onchip_temp_limit_flag = status_one_low[`S1_LIMIT_LO];
    assign remote_diode_one_limit_flag = status_one_low[`S1_LIMIT_LO + 1];
    assign diode_one_fault_flag = fault_flags[0];
    assign diode_two_fault_flag = fault_flags[1];
    assign thermistor_one_fault_flag = fault_flags[2];
    assign thermistor_two_fault_flag = fault_flags[3];

    // ************************************************
    // register images
    // ************************************************
    // upper two bits of status two tied low
    assign event_status_two = {2'b00, thermistor_two_fault_flag, thermistor_one_fault_flag,
                               diode_two_fault_flag, diode_one_fault_flag,
                               processor_hot_flag, critical_overtemp_flag};
    assign summary_limit_flag = |event_status_two;
    assign event_status_one = {summary_limit_flag, status_one_low[6:4],
                               remote_diode_one_limit_flag, onchip_temp_limit_flag,
                               first_fan_stall_flag, second_fan_stall_flag};

    // per-bit gating of status one onto alert
    assign alert_terms = event_status_one & ~event_mask_one;

    // ************************************************
    // flag next values
    // ************************************************
    // set term first: an event in the read cycle keeps its flag
    assign next_limit_flags = limit_hit | (status_one_low & {5{~rd_one}});
    assign next_second_fan_flag = second_fan_stall_flag_event | (second_fan_stall_flag & ~rd_one);
    assign next_first_fan_flag = first_fan_stall_flag_event | (first_fan_stall_flag & ~rd_one);
    // status two clears on its own read, overtemp excepted
    assign next_hot_flag = hot_event | (processor_hot_flag & ~rd_two);
    assign next_fault_flags = sensor_fault | (fault_flags & {4{~rd_two}});

    // ************************************************
    // first status register
    // ************************************************
    // out-of-limit flags: set wins, read clears only when fault gone
    always @(posedge mclk) begin
        if (sys_rst) begin
            status_one_low <= 5'h00;
            second_fan_stall_flag <= 1'b0;
            first_fan_stall_flag <= 1'b0;
        end else begin
            status_one_low <= next_limit_flags;
            second_fan_stall_flag <= next_second_fan_flag;
            first_fan_stall_flag <= next_first_fan_flag;
        end
    end

    // ************************************************
    // second status register
    // ************************************************
    // overtemp self-clears; other flags clear on read when cause gone
    always @(posedge mclk) begin
        if (sys_rst) begin
            critical_overtemp_flag <= 1'b0;
            processor_hot_flag <= 1'b0;
            fault_flags <= 4'h0;
        end else begin
            if (|crit_over) begin
                critical_overtemp_flag <= 1'b1;
            end else if (&crit_below) begin
                critical_overtemp_flag <= 1'b0;
            end
            processor_hot_flag <= next_hot_flag;
            fault_flags <= next_fault_flags;
        end
    end

    // ************************************************
    // assertion timer
    // ************************************************
    // counts assertion time in ticks, saturating, restarts on release
    // saturation keeps a very long assertion flagged
    always @(posedge mclk) begin
        if (sys_rst) begin
            tick_count <= 22'h00_0000;
            hot_time <= 8'h00;
            hot_prev <= 1'b0;
        end else begin
            hot_prev <= processor_hot_input;
            if (!processor_hot_input || !hot_monitor_enable) begin
                tick_count <= 22'h00_0000;
                hot_time <= 8'h00;
            end else if (tick_done) begin
                tick_count <= 22'h00_0000;
                if (hot_time != 8'hFF) begin
                    hot_time <= hot_time + 8'h01;
                end
            end else begin
                tick_count <= tick_count + 22'h00_0001;
            end
        end
    end

    // ************************************************
    // host access
    // ************************************************
    // mask and limit writable, status writes dropped
    always @(posedge mclk) begin
        if (sys_rst) begin
            event_mask_one <= `RST_BYTE;
            hot_limit <= `RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_MASK_ONE: begin
                    event_mask_one <= reg_wdata;
                end
                `ADDR_HOT_LIMIT: begin
                    hot_limit <= reg_wdata;
                end
                default: begin
                    hot_limit <= hot_limit;
                end
            endcase
        end
    end

    // ************************************************
    // read data
    // ************************************************
    // registered read data, unmapped reads give zero
    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= `RST_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_STATUS_ONE: begin
                    reg_rdata <= event_status_one;
                end
                `ADDR_STATUS_TWO: begin
                    reg_rdata <= event_status_two;
                end
                `ADDR_MASK_ONE: begin
                    reg_rdata <= event_mask_one;
                end
                `ADDR_HOT_LIMIT: begin
                    reg_rdata <= hot_limit;
                end
                default: begin
                    reg_rdata <= `RST_BYTE;
                end
            endcase
        end
    end

    // ************************************************
    // alert output
    // ************************************************
    // low while any unmasked event stands
    // status two reaches alert only through summary bit 7
    always @(posedge mclk) begin
        if (sys_rst) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= ~(|alert_terms);
        end
    end

endmodule // monitor_interrupt_status_mask

// [hdl/monitor_irq_regs.vh]
// holds register offsets, field positions, reset values and timing counts
// assumes inclusion by the single monitor interrupt design file
`ifndef MONITOR_IRQ_REGS_VH
`define MONITOR_IRQ_REGS_VH
// register offsets
`define ADDR_STATUS_ONE 8'h10
`define ADDR_STATUS_TWO 8'h11
`define ADDR_MASK_ONE 8'h12
`define ADDR_HOT_LIMIT 8'h1E
// reset values
`define RST_BYTE 8'h00
// first status register fields
`define S1_SECOND_FAN_STALL_FLAG 0
`define S1_FIRST_FAN_STALL_FLAG 1
`define S1_LIMIT_LO 2
`define S1_LIMIT_HI 6
`define S1_SUMMARY 7
// second status register fields
`define S2_OVT 0
`define S2_HOT 1
`define S2_FAULT_LO 2
`define S2_FAULT_HI 5
// number of compared channels
`define LIMIT_CHANNELS 5
`define CRIT_CHANNELS 4
// assertion timer resolution
`define HOT_TICK_NS 22760000
`define CLK_PERIOD_NS 10
`define HOT_TICK_CYCLES (`HOT_TICK_NS / `CLK_PERIOD_NS)
`endif

// [dv/host_bus.sv]
// host model issuing single-byte register reads and writes
// assumes the block samples strobes on the rising mclk edge
`timescale 1ns/1ps
module host_bus (
    input wire mclk,
    output reg [7:0] reg_addr = 8'h00,
    output reg reg_wr = 1'b0,
    output reg reg_rd = 1'b0,
    output reg [7:0] reg_wdata = 8'h00,
    input wire [7:0] reg_rdata
);
    // one-cycle write strobe
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(negedge mclk);
            reg_addr = a;
            reg_wdata = v;
            reg_wr = 1'b1;
            @(negedge mclk);
            reg_wr = 1'b0;
        end
    endtask
    // one-cycle read strobe, data the next cycle
    task rd(input [7:0] a, output [7:0] v);
        begin
            @(negedge mclk);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge mclk);
            reg_rd = 1'b0;
            v = reg_rdata;
        end
    endtask
endmodule // host_bus

// [dv/monitor_interrupt_status_mask_props.sv]
// alert and read data timing checks at the block's ports
// assumes the bind below; mask mirrored from observed writes
`timescale 1ns/1ps
module monitor_interrupt_status_mask_props (
    input wire mclk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [1:0] fan_slow,
    input wire [7:0] first_fan_drive_output,
    input wire [39:0] limit_reading,
    input wire [39:0] limit_high,
    input wire [31:0] crit_reading,
    input wire [31:0] crit_limit,
    input wire [3:0] sensor_fault,
    input wire alert_n
);
    // ****
    // mask mirror and properties
    // ****
    reg [7:0] msk;
    // mirror of mask one
    always @(posedge mclk) begin
        if (sys_rst) begin
            msk <= 8'h00;
        end else if (reg_wr && reg_addr == 8'h12) begin
            msk <= reg_wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // flag one edge, alert the next
    sequence s_alert;
        ##2 !alert_n;
    endsequence
    AST_RESET: assert property (disable iff (1'b0) sys_rst |=> alert_n && reg_rdata == 8'h00)
        else $error("reset values wrong");
    AST_S2_TOP: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata[7:6] == 2'b00)
        else $error("unused status two bits set");
    AST_LOC: assert property (limit_reading[7:0] > limit_high[7:0] && !msk[2] && !reg_wr |-> s_alert)
        else $error("on-chip limit missed alert");
    AST_REM: assert property (limit_reading[15:8] > limit_high[15:8] && !msk[3] && !reg_wr |-> s_alert)
        else $error("remote limit missed alert");
    AST_FAN: assert property (fan_slow[0] && first_fan_drive_output != 8'h00 && !msk[1] && !reg_wr |-> s_alert)
        else $error("fan stall missed alert");
    AST_OVT: assert property (crit_reading[7:0] > crit_limit[7:0] && crit_limit[7:0] != 8'h00 && !msk[7]
        && !reg_wr |-> s_alert) else $error("overtemp missed alert");
    AST_FAULT: assert property (|sensor_fault && !msk[7] && !reg_wr |-> s_alert)
        else $error("sensor fault missed alert");
    AST_MASKED: assert property (msk == 8'hFF |=> alert_n)
        else $error("masked event reached alert");
endmodule // monitor_interrupt_status_mask_props

bind monitor_interrupt_status_mask monitor_interrupt_status_mask_props i_props (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fan_slow(fan_slow), .first_fan_drive_output(first_fan_drive_output), .limit_reading(limit_reading),
    .limit_high(limit_high), .crit_reading(crit_reading), .crit_limit(crit_limit),
    .sensor_fault(sensor_fault), .alert_n(alert_n));

// [dv/monitor_interrupt_status_mask_tb.sv]
// self-checking bench for the interrupt status and mask block
// assumes host_bus for register access, HOT_TICK cut to 8
`timescale 1ns/1ps
module monitor_interrupt_status_mask_tb;
    // ****
    // stimulus, checks and verdict
    // ****
    reg mclk = 1'b0, sys_rst = 1'b1, hot_en = 1'b0, hot = 1'b0;
    reg [1:0] fan = 2'h0;
    reg [3:0] flt = 4'h0;
    reg [7:0] drv = 8'h00, drv2 = 8'h00, d;
    reg [39:0] lrd = {5{8'h10}}, lhi = {5{8'hF0}}, llo = {5{8'h00}};
    reg [31:0] crd = 32'h0000_0000, clim = 32'h0000_0050;
    wire [7:0] addr, wdat, rdat;
    wire wr, rd, alert_n;
    integer err_total = 0, checked = 0, k;
    // 100 MHz clock
    always #5 mclk = ~mclk;
    monitor_interrupt_status_mask #(.HOT_TICK(8)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(addr),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdat), .reg_rdata(rdat), .fan_slow(fan),
        .first_fan_drive_output(drv), .second_fan_drive_output(drv2), .limit_reading(lrd), .limit_low(llo),
        .limit_high(lhi), .crit_reading(crd), .crit_limit(clim), .overtemp_hysteresis(8'h05),
        .hot_monitor_enable(hot_en), .processor_hot_input(hot), .sensor_fault(flt), .alert_n(alert_n));
    host_bus i_host (.mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdat), .reg_rdata(rdat));
    // read a register, compare masked bits
    task chk(input [7:0] a, input [7:0] e, input [7:0] m);
        begin
            i_host.rd(a, d);
            checked = checked + 1;
            if ((d & m) !== e) begin
                err_total = err_total + 1;
                $display("FAIL reg %h exp %h got %h", a, e, d & m);
            end
        end
    endtask
    // let a flag reach the alert pin
    task achk(input e);
        begin
            repeat (3) @(negedge mclk);
            checked = checked + 1;
            if (alert_n !== e) begin
                err_total = err_total + 1;
                $display("FAIL alert_n exp %b got %b", e, alert_n);
            end
        end
    endtask
    task t_msk;
        begin
            chk(8'h10, 8'h00, 8'hFF);
            chk(8'h11, 8'h00, 8'hFF);
            chk(8'h12, 8'h00, 8'hFF);
            i_host.wr(8'h10, 8'hFF);
            i_host.wr(8'h12, 8'hFF);
            chk(8'h10, 8'h00, 8'hFF);
            chk(8'h12, 8'hFF, 8'hFF);
            lrd[7:0] = 8'hF1;
            achk(1'b1);
            i_host.wr(8'h12, 8'h00);
            achk(1'b0);
            lrd[7:0] = 8'h10;
            chk(8'h10, 8'h04, 8'h7F);
            achk(1'b1);
        end
    endtask
    task t_lim;
        begin
            for (k = 0; k < 5; k = k + 1) begin
                lrd[k*8 +: 8] = 8'hF1;
                chk(8'h10, 8'h04 << k, 8'h7F);
                chk(8'h10, 8'h04 << k, 8'h7F);
                lrd[k*8 +: 8] = 8'h10;
                chk(8'h10, 8'h04 << k, 8'h7F);
            end
            llo[15:8] = 8'h10;
            chk(8'h10, 8'h08, 8'h7F);
            llo[15:8] = 8'h00;
            chk(8'h10, 8'h08, 8'h7F);
            chk(8'h10, 8'h00, 8'h7F);
        end
    endtask
    task t_st2;
        begin
            crd[7:0] = 8'h51;
            chk(8'h11, 8'h01, 8'hFF);
            chk(8'h10, 8'h80, 8'h80);
            i_host.wr(8'h12, 8'h80);
            achk(1'b1);
            i_host.wr(8'h12, 8'h00);
            crd[7:0] = 8'h4B;
            achk(1'b0);
            crd[7:0] = 8'h4A;
            achk(1'b1);
            clim[31:24] = 8'h40;
            crd[31:24] = 8'h41;
            chk(8'h11, 8'h01, 8'h01);
            crd[31:24] = 8'h00;
            chk(8'h11, 8'h00, 8'h01);
            flt = 4'hF;
            chk(8'h11, 8'h3C, 8'hFF);
            flt = 4'h0;
        end
    endtask
    task t_fh;
        begin
            fan = 2'h3;
            chk(8'h10, 8'h00, 8'h03);
            drv = 8'h80;
            chk(8'h10, 8'h02, 8'h03);
            drv2 = 8'h80;
            chk(8'h10, 8'h03, 8'h03);
            hot_en = 1'b1;
            hot = 1'b1;
            chk(8'h11, 8'h3E, 8'hFF);
            hot = 1'b0;
            i_host.wr(8'h1E, 8'h02);
            chk(8'h11, 8'h00, 8'h02);
            hot = 1'b1;
            chk(8'h11, 8'h00, 8'hFF);
            repeat (40) @(negedge mclk);
            chk(8'h11, 8'h02, 8'hFF);
        end
    endtask
    // verdict
    task test_done;
        begin
            $display("checked %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        t_msk;
        t_lim;
        t_st2;
        t_fh;
        test_done;
    end
    // watchdog
    initial begin
        #100000;
        err_total = err_total + 1;
        test_done;
    end
endmodule // monitor_interrupt_status_mask_tb
